// *** dmars_regs.svh ***
`ifndef DMARS_REGS_SVH
`define DMARS_REGS_SVH

`define DMARS_OPCTL_OFS    8'h00
`define DMARS_CH2CTL_OFS   8'h04
`define DMARS_CH2SRC_OFS   8'h08
`define DMARS_CH2DST_OFS   8'h0C
`define DMARS_CH2CNT_OFS   8'h10
`define DMARS_STATUS_OFS   8'h14

`define DMARS_OP_ME_BIT    0
`define DMARS_OP_NONMASKABLE_IRQ_FLAG_BIT  1
`define DMARS_OP_AE_BIT    2

`define DMARS_CC_EN_BIT    0
`define DMARS_CC_IE_BIT    1
`define DMARS_CC_TE_BIT    2
`define DMARS_CC_BURST_BIT 3
`define DMARS_CC_EDGE_BIT  4
`define DMARS_CC_RLD_BIT   5
`define DMARS_CC_SZ_LSB    6
`define DMARS_CC_DINC_BIT  8
`define DMARS_CC_SINC_BIT  9
`define DMARS_CC_ACKW_BIT  10

`define DMARS_SECOND_SAMPLE 2'h2
`define DMARS_MAX_PENDING   2'h2
`define DMARS_RELOAD_LAST   2'h3
`define DMARS_SIZE_16BYTE   2'h3

`endif

// *** dmars_pkg.sv ***
package dmars_pkg;

  typedef logic [23:0] dmars_count_t;

  typedef enum logic [2:0] {
    DMARS_IDLE  = 3'b000,
    DMARS_WAIT  = 3'b001,
    DMARS_READ  = 3'b010,
    DMARS_WRITE = 3'b011,
    DMARS_GAP   = 3'b100
  } dmars_state_t;

  typedef struct packed {
    logic prev_level;
    logic edge_held;
  } dmars_smp_t;

  typedef struct packed {
    dmars_state_t state;
    logic [1:0]   wait_cnt;
    logic [3:0]   acc_cnt;
    logic [1:0]   pending;
    logic         hunt;
    logic         burst_run;
    logic         master_enable;
    logic         nmi_flag;
    logic         ae_flag;
    logic         nmi_prev;
    logic         ch_en;
    logic         ie;
    logic         te;
    logic         burst;
    logic         edge_mode;
    logic         reload;
    logic [1:0]   usize;
    logic         dst_inc;
    logic         src_inc;
    logic         ack_on_write;
    logic [31:0]  src_start;
    logic [31:0]  src;
    logic [31:0]  dst;
    dmars_count_t count;
    logic [1:0]   rld_cnt;
    logic [31:0]  data;
    logic [31:0]  rdata;
  } dmars_st_t;

endpackage

// *** dmars_sampler.sv ***
`timescale 1ns/1ns
// request pin sampler; a falling edge is held until used or discarded
module dmars_sampler
  import dmars_pkg::*;
(
  input  wire logic core_clk,
  input  wire logic reset_n,
  input  wire logic xfer_request_n,
  input  wire logic edge_mode,
  input  wire logic consume,
  input  wire logic discard,
  output logic      req_seen
);

  dmars_smp_t st_reg;
  dmars_smp_t st_next;
  logic       fall_now;

  assign fall_now = st_reg.prev_level & ~xfer_request_n;
  // edge or low level, selected by mode
  assign req_seen = edge_mode ? (st_reg.edge_held | fall_now)
                              : ~xfer_request_n;

  always_comb begin
    st_next = st_reg;
    st_next.prev_level = xfer_request_n;
    if (consume || discard) begin
      st_next.edge_held = 1'b0;
    end else if (fall_now && edge_mode) begin
      st_next.edge_held = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= '{prev_level: 1'b1, edge_held: 1'b0};
    end else begin
      st_reg <= st_next;
    end
  end

endmodule

// *** dmars_core.sv ***
// The placing of the registers and the plain strobed port are this design's own decisions.
`timescale 1ns/1ns
`include "dmars_regs.svh"
// What this block does
// - request pin detected by falling edge or low level, as programmed.
// - cycle-steal sampling timing identical for level and edge detection.
// - first bus cycle starts three cycles after the first sample.
// - second sample taken two cycles after the first.
// - missed second sample: sample every following cycle until seen.
// - cycle-steal third sample waits for idle cycle after first transfer.
// - acknowledge follows chip select of the access to the requester.
// - burst level: further samples in idle cycle after each transfer.
// - burst level: request high releases bus after accepted transfers.
// - burst edge: sample once, then run until count exhausted.
// - reload enabled: source address restored every four transfers.
// - reload only for 8, 16, 32 bit units, not 16 bytes.
// - count drops one per transfer; software programs multiples of four.
// - reload counter cleared by disables, end flag, errors, nmi, reset.
// - ending condition stops acceptance; accepted transfers still finish.
// - burst edge: stop sampled at cycle-steal timing, cover gap first.
// - stop only at transfer boundary; paired write always completes.
// - count zero at transfer end sets end flag, interrupt if enabled.
// - clearing channel enable ends gracefully, no end flag.
// - nmi sets flag, all channels stop gracefully, no end flag.
// - clearing master enable ends all gracefully, no end flag.
module dmars_core
  import dmars_pkg::*;
#(
  parameter logic [3:0] ACC_CYCLES = 4'h2
)(
  input  wire logic  core_clk,
  input  wire logic  reset_n,
  input  wire logic  [7:0]  reg_addr,
  input  wire logic  [31:0] reg_wdata,
  input  wire logic  reg_write,
  input  wire logic  reg_read,
  output logic       [31:0] reg_rdata,
  input  wire logic  xfer_request_n,
  output logic       xfer_acknowledge,
  output logic       chip_select_strobe_n,
  output logic       [31:0] bus_address,
  output logic       bus_read,
  output logic       bus_write,
  input  wire logic  [31:0] bus_rdata,
  output logic       [31:0] bus_wdata,
  output logic       bus_owned,
  input  wire logic  nmi_request,
  input  wire logic  address_error,
  output logic       transfer_end_irq
);

  dmars_st_t    st_reg;
  dmars_st_t    st_next;
  logic         ending;
  logic         size_ok;
  logic         in_flight;
  dmars_count_t need;
  logic         can_accept;
  logic         sample_en;
  logic         smp_seen;
  logic         req;
  logic         hit;
  logic         launch;
  logic         xfer_done;
  logic         te_set;
  logic         nmi_set;
  logic         acc_last;
  logic [31:0]  unit_bytes;

  // the held edge is consumed only when it becomes a transfer
  dmars_sampler u_sampler (
    .core_clk       (core_clk),
    .reset_n        (reset_n),
    .xfer_request_n (xfer_request_n),
    .edge_mode      (st_reg.edge_mode),
    .consume        (hit),
    .discard        (ending),
    .req_seen       (smp_seen)
  );

  // any of these stops acceptance on the channel
  assign ending = ~st_reg.master_enable | st_reg.nmi_flag | st_reg.ae_flag
                | ~st_reg.ch_en | st_reg.te;
  // 16-byte unit refused while reload is on
  assign size_ok = ~(st_reg.reload
                   && st_reg.usize == `DMARS_SIZE_16BYTE);
  assign in_flight = (st_reg.state == DMARS_READ)
                   | (st_reg.state == DMARS_WRITE);
  assign need = dmars_count_t'(st_reg.pending)
              + dmars_count_t'(in_flight);
  // never accept more transfers than the count still covers
  assign can_accept = ~ending & size_ok
                    & (st_reg.pending < `DMARS_MAX_PENDING)
                    & (st_reg.count > need);

  // sample points do not depend on edge or level mode
  assign sample_en = (st_reg.state == DMARS_IDLE)
    | (st_reg.state == DMARS_WAIT
       && st_reg.wait_cnt == `DMARS_SECOND_SAMPLE)
    | (st_reg.state == DMARS_GAP)
    | (st_reg.hunt && st_reg.state != DMARS_GAP);
  // a running edge burst counts as a standing request
  assign req = st_reg.burst_run | smp_seen;
  assign hit = sample_en & req & can_accept;

  assign acc_last = (st_reg.acc_cnt == ACC_CYCLES);
  assign xfer_done = (st_reg.state == DMARS_WRITE) & acc_last;
  assign te_set = xfer_done
                & (st_reg.count == dmars_count_t'(1));
  assign nmi_set = nmi_request & ~st_reg.nmi_prev;
  assign launch = ((st_reg.state == DMARS_WAIT)
                   && st_reg.wait_cnt == `DMARS_SECOND_SAMPLE)
                | ((st_reg.state == DMARS_GAP)
                   && st_reg.pending != 2'h0);

  always_comb begin
    unit_bytes = 32'h00000001;
    case (st_reg.usize)
      2'h0: unit_bytes = 32'h00000001;
      2'h1: unit_bytes = 32'h00000002;
      2'h2: unit_bytes = 32'h00000004;
      default: unit_bytes = 32'h00000010;
    endcase
  end

  always_comb begin
    st_next = st_reg;
    st_next.rdata = 32'h00000000;
    st_next.nmi_prev = nmi_request;
    st_next.pending = st_reg.pending + {1'b0, hit}
                    - {1'b0, launch};

    // hunting starts on a missed pipeline sample, ends on a hit
    if (hit || !can_accept) begin
      st_next.hunt = 1'b0;
    end else if (sample_en && !req
                 && st_reg.state != DMARS_IDLE) begin
      st_next.hunt = 1'b1;
    end

    if (hit && st_reg.burst && st_reg.edge_mode) begin
      st_next.burst_run = 1'b1;
    end
    if (ending || te_set) begin
      st_next.burst_run = 1'b0;
    end

    case (st_reg.state)
      DMARS_IDLE: begin
        if (hit) begin
          st_next.state = DMARS_WAIT;
          st_next.wait_cnt = 2'h1;
        end
      end
      DMARS_WAIT: begin
        st_next.wait_cnt = st_reg.wait_cnt + 2'h1;
        if (st_reg.wait_cnt == `DMARS_SECOND_SAMPLE) begin
          st_next.state = DMARS_READ;
          st_next.acc_cnt = 4'h1;
        end
      end
      DMARS_READ: begin
        st_next.acc_cnt = st_reg.acc_cnt + 4'h1;
        if (acc_last) begin
          // the write always follows, even after an ending condition
          st_next.data = bus_rdata;
          st_next.state = DMARS_WRITE;
          st_next.acc_cnt = 4'h1;
        end
      end
      DMARS_WRITE: begin
        st_next.acc_cnt = st_reg.acc_cnt + 4'h1;
        if (acc_last) begin
          st_next.state = DMARS_GAP;
          st_next.count = st_reg.count - dmars_count_t'(1);
          if (st_reg.dst_inc) begin
            st_next.dst = st_reg.dst + unit_bytes;
          end
          if (st_reg.reload && st_reg.rld_cnt == `DMARS_RELOAD_LAST) begin
            st_next.src = st_reg.src_start;
          end else if (st_reg.src_inc) begin
            st_next.src = st_reg.src + unit_bytes;
          end
          if (st_reg.reload) begin
            st_next.rld_cnt = st_reg.rld_cnt + 2'h1;
          end
        end
      end
      DMARS_GAP: begin
        // idle cycle; already accepted work resumes, else restart
        if (st_reg.pending != 2'h0) begin
          st_next.state = DMARS_READ;
          st_next.acc_cnt = 4'h1;
        end else if (hit) begin
          st_next.state = DMARS_WAIT;
          st_next.wait_cnt = 2'h1;
        end else begin
          st_next.state = DMARS_IDLE;
        end
      end
      default: begin
        st_next.state = DMARS_IDLE;
      end
    endcase

    // flag set beats a software clear in the same cycle
    if (te_set) begin
      st_next.te = 1'b1;
    end
    if (nmi_set) begin
      st_next.nmi_flag = 1'b1;
    end
    if (address_error) begin
      st_next.ae_flag = 1'b1;
    end

    if (reg_write) begin
      if (reg_addr == `DMARS_OPCTL_OFS) begin
        st_next.master_enable = reg_wdata[`DMARS_OP_ME_BIT];
        st_next.nmi_flag = (st_reg.nmi_flag
                            & reg_wdata[`DMARS_OP_NONMASKABLE_IRQ_FLAG_BIT]) | nmi_set;
        st_next.ae_flag = (st_reg.ae_flag
                           & reg_wdata[`DMARS_OP_AE_BIT]) | address_error;
      end else if (reg_addr == `DMARS_CH2CTL_OFS) begin
        st_next.ch_en = reg_wdata[`DMARS_CC_EN_BIT];
        st_next.ie = reg_wdata[`DMARS_CC_IE_BIT];
        st_next.te = (st_reg.te & reg_wdata[`DMARS_CC_TE_BIT]) | te_set;
        st_next.burst = reg_wdata[`DMARS_CC_BURST_BIT];
        st_next.edge_mode = reg_wdata[`DMARS_CC_EDGE_BIT];
        st_next.reload = reg_wdata[`DMARS_CC_RLD_BIT];
        st_next.usize = reg_wdata[`DMARS_CC_SZ_LSB +: 2];
        st_next.dst_inc = reg_wdata[`DMARS_CC_DINC_BIT];
        st_next.src_inc = reg_wdata[`DMARS_CC_SINC_BIT];
        st_next.ack_on_write = reg_wdata[`DMARS_CC_ACKW_BIT];
      end else if (reg_addr == `DMARS_CH2SRC_OFS) begin
        st_next.src = reg_wdata;
        st_next.src_start = reg_wdata;
      end else if (reg_addr == `DMARS_CH2DST_OFS) begin
        st_next.dst = reg_wdata;
      end else if (reg_addr == `DMARS_CH2CNT_OFS) begin
        // software write of the count wins over a decrement
        st_next.count = reg_wdata[23:0];
      end
    end

    // addresses and count are left as they stand
    if (!st_next.master_enable || !st_next.ch_en || st_next.ae_flag
        || st_next.nmi_flag || te_set) begin
      st_next.rld_cnt = 2'h0;
    end

    if (reg_read) begin
      if (reg_addr == `DMARS_OPCTL_OFS) begin
        st_next.rdata = {29'h0, st_reg.ae_flag, st_reg.nmi_flag,
                         st_reg.master_enable};
      end else if (reg_addr == `DMARS_CH2CTL_OFS) begin
        st_next.rdata = {21'h0, st_reg.ack_on_write, st_reg.src_inc,
                         st_reg.dst_inc, st_reg.usize, st_reg.reload,
                         st_reg.edge_mode, st_reg.burst, st_reg.te,
                         st_reg.ie, st_reg.ch_en};
      end else if (reg_addr == `DMARS_CH2SRC_OFS) begin
        st_next.rdata = st_reg.src;
      end else if (reg_addr == `DMARS_CH2DST_OFS) begin
        st_next.rdata = st_reg.dst;
      end else if (reg_addr == `DMARS_CH2CNT_OFS) begin
        st_next.rdata = {8'h0, st_reg.count};
      end else if (reg_addr == `DMARS_STATUS_OFS) begin
        st_next.rdata = {22'h0, st_reg.burst_run, st_reg.hunt,
                         st_reg.rld_cnt, st_reg.pending, 1'b0,
                         st_reg.state};
      end else begin
        st_next.rdata = 32'h00000000;
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata = st_reg.rdata;
  assign bus_read = (st_reg.state == DMARS_READ);
  assign bus_write = (st_reg.state == DMARS_WRITE);
  assign chip_select_strobe_n = ~in_flight;
  // requester sits on the read side unless told otherwise
  assign xfer_acknowledge = st_reg.ack_on_write ? bus_write
                                                : bus_read;
  assign bus_address = bus_write ? st_reg.dst : st_reg.src;
  assign bus_wdata = st_reg.data;
  // cycle steal hands the bus back in every idle cycle
  assign bus_owned = in_flight
                   | (st_reg.burst && st_reg.state == DMARS_GAP
                      && st_reg.pending != 2'h0);
  assign transfer_end_irq = st_reg.te & st_reg.ie;

endmodule

// *** dmars_peer.sv ***
`timescale 1ns/1ns
// requesting peripheral and the memory behind the read accesses
module dmars_peer (
  input  wire logic        core_clk,
  input  wire logic        want,
  input  wire logic        bus_read,
  input  wire logic [31:0] bus_address,
  output logic             xfer_request_n,
  output logic [31:0]      bus_rdata
);
  logic [31:0] junk = 32'h0;
  logic        req_q = 1'b1;
  always @(posedge core_clk) begin
    req_q <= !want;
    junk <= junk + 32'h9E37_79B9;
  end
  assign xfer_request_n = req_q;
  // outside reads the data bus is released: garbage that moves each cycle
  assign bus_rdata = bus_read ? (bus_address ^ 32'hC3A5_0F96) : junk;
endmodule

// *** dmars_chk.sv ***
`timescale 1ns/1ns
`include "dmars_regs.svh"
module dmars_chk (
  input wire logic        core_clk,
  input wire logic        reset_n,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_write,
  input wire logic        xfer_acknowledge,
  input wire logic        chip_select_strobe_n,
  input wire logic        bus_read,
  input wire logic        bus_write,
  input wire logic        bus_owned,
  input wire logic        nmi_request,
  input wire logic        transfer_end_irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  // pending plus in-flight transfers drain well inside the bound
  sequence s_quiet;
    (chip_select_strobe_n && !bus_owned) [*6];
  endsequence
  sequence s_op_off;
    reg_write && reg_addr == `DMARS_OPCTL_OFS && !reg_wdata[`DMARS_OP_ME_BIT];
  endsequence
  sequence s_ch_off;
    reg_write && reg_addr == `DMARS_CH2CTL_OFS && !reg_wdata[`DMARS_CC_EN_BIT];
  endsequence
  chk_ack_in_cs: assert property (
    xfer_acknowledge |-> !chip_select_strobe_n && (bus_read != bus_write))
    else $error("acknowledge outside an access");
  chk_cs_is_access: assert property (
    chip_select_strobe_n == !(bus_read || bus_write))
    else $error("chip select does not match access");
  chk_read_then_write: assert property (
    $fell(bus_read) |-> bus_write)
    else $error("read not followed by its write");
  chk_gap_after: assert property (
    $fell(bus_write) |-> chip_select_strobe_n)
    else $error("no idle cycle after transfer");
  chk_first_three: assert property (
    $fell(chip_select_strobe_n) && $past(chip_select_strobe_n, 2)
      |-> $past(chip_select_strobe_n, 3))
    else $error("bus cycle too soon after sample");
  chk_nmi_stop: assert property (
    $rose(nmi_request) |-> ##[1:20] s_quiet)
    else $error("transfers go on after nmi");
  chk_me_clear_stop: assert property (
    s_op_off |-> ##[1:20] s_quiet)
    else $error("transfers go on after master disable");
  chk_ch_clear_stop: assert property (
    s_ch_off |-> ##[1:20] s_quiet)
    else $error("transfers go on after channel disable");
  chk_irq_cause: assert property (
    $rose(transfer_end_irq) |-> $past(reg_write) || $past(bus_write)
      || $past(bus_write, 2))
    else $error("end interrupt without a final write");
endmodule

// *** tb_top.sv ***
`timescale 1ns/1ns
`include "dmars_regs.svh"
module tb_top;
  logic        core_clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_write = 1'b0;
  logic        reg_read = 1'b0;
  logic        want = 1'b0;
  logic        nmi_request = 1'b0;
  logic        address_error = 1'b0;
  logic [31:0] reg_rdata, bus_address, bus_rdata, bus_wdata, src, dst;
  logic        xfer_request_n, xfer_acknowledge, chip_select_strobe_n;
  logic        bus_read, bus_write, bus_owned, transfer_end_irq;
  logic        wr_q = 1'b0;
  logic        rd_q = 1'b0;
  logic [31:0] raddr[$];
  logic [31:0] waddr[$];
  logic        ack_w = 1'b0;
  int          n_fail, checks_done, n_wr;
  int          wr_tot, wr_base, rbase, ack_tot, ack_base;
  assign n_wr = wr_tot - wr_base;
  localparam logic [7:0] OP = `DMARS_OPCTL_OFS;
  localparam logic [7:0] CTL = `DMARS_CH2CTL_OFS;
  localparam logic [7:0] CNT = `DMARS_CH2CNT_OFS;
  always #25 core_clk = !core_clk;
  dmars_core #(.ACC_CYCLES(4'h2)) dmars_core_i (
    .core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .xfer_request_n(xfer_request_n),
    .xfer_acknowledge(xfer_acknowledge),
    .chip_select_strobe_n(chip_select_strobe_n), .bus_address(bus_address),
    .bus_read(bus_read), .bus_write(bus_write), .bus_rdata(bus_rdata),
    .bus_wdata(bus_wdata), .bus_owned(bus_owned), .nmi_request(nmi_request),
    .address_error(address_error), .transfer_end_irq(transfer_end_irq));
  dmars_peer dmars_peer_i (.core_clk(core_clk), .want(want),
    .bus_read(bus_read), .bus_address(bus_address),
    .xfer_request_n(xfer_request_n), .bus_rdata(bus_rdata));
  always @(posedge core_clk) begin
    if (bus_write && !wr_q) wr_tot <= wr_tot + 1;
    if (bus_read && !rd_q) raddr.push_back(bus_address);
    if (bus_write && !wr_q) waddr.push_back(bus_address);
    if (xfer_acknowledge && (ack_w ? bus_write : bus_read))
      ack_tot <= ack_tot + 1;
    wr_q <= bus_write;
    rd_q <= bus_read;
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_write <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] e);
    @(posedge core_clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_read <= 1'b0;
    #1 chk(reg_rdata & m, e);
  endtask
  task automatic wait_idle();
    int q;
    q = 0;
    for (int i = 0; i < 2000 && q < 8; i++) begin
      @(posedge core_clk);
      q = (chip_select_strobe_n === 1'b1 && bus_owned === 1'b0) ? q + 1 : 0;
    end
    if (q < 8) begin
      n_fail++;
      report_and_stop();
    end
  endtask
  task automatic wait_wr(input int n);
    for (int i = 0; i < 500 && n_wr < n; i++) @(posedge core_clk);
    if (n_wr < n) begin
      n_fail++;
      report_and_stop();
    end
  endtask
  // one peer register stage sits before the sampler, hence one extra edge
  task automatic go(input bit edg);
    int n;
    n = 0;
    @(posedge core_clk);
    want <= 1'b1;
    while (chip_select_strobe_n === 1'b1 && n < 50) begin
      @(posedge core_clk);
      #1 n++;
    end
    chk(n, 4);
    if (edg) want <= 1'b0;
  endtask
  task automatic setup(input logic [31:0] c, input logic [23:0] n);
    src = $urandom & 32'h00FF_FFF0;
    dst = $urandom & 32'h0FFF_FFF0;
    wr(`DMARS_CH2SRC_OFS, src);
    wr(`DMARS_CH2DST_OFS, dst);
    wr(CNT, {8'h00, n});
    wr(CTL, c);
    wr(OP, 32'h1);
    wr_base = wr_tot;
    ack_base = ack_tot;
    rbase = raddr.size();
  endtask
  function automatic logic [31:0] exp_addr(int i, bit rl, int unit);
    return src + unit * (rl ? i % 4 : i);
  endfunction
  initial begin
    repeat (100000) @(posedge core_clk);
    n_fail++;
    report_and_stop();
  end
  initial begin
    int cnt;
    n_fail = 0;
    checks_done = 0;
    void'($urandom(31987));
    repeat (16) @(posedge core_clk);
    reset_n <= 1'b1;
    // reset values, then one unmapped place
    for (int a = 0; a < 32'h1C; a += 4) rdchk(8'(a), '1, 32'h0);
    // cycle-steal, level, 4-byte units, acknowledge on read or on write
    cnt = 2 + $urandom % 3;
    ack_w = 1'($urandom % 2);
    setup(32'h0383 | (32'(ack_w) << 10), 24'(cnt));
    go(1'b0);
    wait_idle();
    want <= 1'b0;
    chk(n_wr, cnt);
    for (int i = rbase; i < raddr.size(); i++)
      chk(raddr[i], exp_addr(i - rbase, 0, 4));
    for (int i = rbase; i < waddr.size(); i++)
      chk(waddr[i], dst + 32'(4 * (i - rbase)));
    chk(ack_tot - ack_base, 2 * cnt);
    rdchk(CNT, 32'hFF_FFFF, 32'h0);
    rdchk(CTL, 32'h4, 32'h4);
    chk(32'(transfer_end_irq), 32'h1);
    chk(bus_wdata, exp_addr(cnt - 1, 0, 4) ^ 32'hC3A5_0F96);
    // reload with 16-byte units must stay idle
    want <= 1'b1;
    setup(32'h02E9, 24'd8);
    repeat (20) @(posedge core_clk);
    chk(n_wr, 0);
    // burst level, 2-byte units, reload; count a multiple of four
    setup(32'h0269, 24'd8);
    wait_idle();
    chk(raddr.size() - rbase, 8);
    for (int i = rbase; i < raddr.size(); i++)
      chk(raddr[i], exp_addr(i - rbase, 1, 2));
    rdchk(CTL, 32'h4, 32'h4);
    chk(32'(transfer_end_irq), 32'h0);
    // burst edge, nmi in mid-run, then restart
    want <= 1'b0;
    setup(32'h0399, 24'd20);
    go(1'b1);
    wait_wr(3);
    nmi_request <= 1'b1;
    wait_idle();
    chk(32'(n_wr < 20), 32'h1);
    rdchk(CNT, 32'hFF_FFFF, 20 - n_wr);
    rdchk(CTL, 32'h4, 32'h0);
    rdchk(OP, 32'h2, 32'h2);
    nmi_request <= 1'b0;
    wr(OP, 32'h1);
    go(1'b1);
    wait_idle();
    chk(n_wr, 20);
    rdchk(CNT, 32'hFF_FFFF, 32'h0);
    // graceful stop by master disable, by channel disable, by burst release
    for (int k = 0; k < 3; k++) begin
      want <= 1'b1;
      setup(k == 2 ? 32'h038B : 32'h0383, 24'd10);
      wait_wr(2);
      if (k == 0) wr(OP, 32'h0);
      else if (k == 1) wr(CTL, 32'h0382);
      want <= 1'b0;
      wait_idle();
      chk(32'(n_wr < 10), 32'h1);
      rdchk(CNT, 32'hFF_FFFF, 10 - n_wr);
      rdchk(CTL, 32'h4, 32'h0);
    end
    // request gone at the second sample, back for two cycles mid-transfer
    setup(32'h0381, 24'd4);
    @(posedge core_clk);
    want <= 1'b1;
    @(posedge core_clk);
    want <= 1'b0;
    repeat (4) @(posedge core_clk);
    want <= 1'b1;
    repeat (2) @(posedge core_clk);
    want <= 1'b0;
    wait_idle();
    chk(n_wr, 2);
    // address error blocks requests until its flag is cleared
    setup(32'h0383, 24'd4);
    address_error <= 1'b1;
    @(posedge core_clk);
    address_error <= 1'b0;
    want <= 1'b1;
    repeat (20) @(posedge core_clk);
    chk(n_wr, 0);
    rdchk(OP, 32'h4, 32'h4);
    wr(OP, 32'h1);
    wait_wr(4);
    wait_idle();
    chk(n_wr, 4);
    report_and_stop();
  end
endmodule
bind dmars_core dmars_chk dmars_chk_i (.core_clk(core_clk),
  .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .xfer_acknowledge(xfer_acknowledge),
  .chip_select_strobe_n(chip_select_strobe_n), .bus_read(bus_read),
  .bus_write(bus_write), .bus_owned(bus_owned), .nmi_request(nmi_request),
  .transfer_end_irq(transfer_end_irq));
